//--- lmf_pkg.sv
`default_nettype none
package lmf_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_CFG     = 8'h50;
  localparam logic [7:0] ADDR_GCS     = 8'h51;
  localparam logic [7:0] ADDR_PRS     = 8'h52;
  localparam logic [7:0] ADDR_RES_LO  = 8'h53;
  localparam logic [7:0] ADDR_RES_HI  = 8'h5e;
  localparam logic [7:0] ADDR_TRS     = 8'h5f;
  localparam logic [7:0] ADDR_SSC     = 8'h60;
  // ----------------------------------------
  // Reset values and masks
  // ----------------------------------------
  localparam logic [7:0] RST_CFG      = 8'h00;
  localparam logic [7:0] RST_GCS      = 8'h00;
  localparam logic [7:0] RST_PRS      = 8'h33;
  localparam logic [7:0] RST_TRS      = 8'h00;
  localparam logic [7:0] RST_SSC      = 8'h00;
  localparam logic [7:0] MASK_CFG     = 8'hf7;
  localparam logic [7:0] MASK_PRS     = 8'hf7;
  localparam logic [7:0] MASK_TRS     = 8'h0f;
  localparam logic [7:0] MASK_SSC     = 8'h1f;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CFG_SSD    = 0;
  localparam int CFG_DET_LO = 1;
  localparam int CFG_DET_HI = 2;
  localparam int CFG_SWS_LO = 4;
  localparam int CFG_SWS_HI = 7;
  localparam int PRS_CPU_LO = 0;
  localparam int PRS_CPU_HI = 2;
  localparam int PRS_RPD_LO = 4;
  localparam int PRS_RPD_HI = 6;
  localparam int PRS_PHC    = 7;
  localparam int TRS_ROF_LO = 0;
  localparam int TRS_ROF_HI = 1;
  localparam int TRS_TP_LO  = 2;
  localparam int TRS_TP_HI  = 3;
  localparam int RES_COUNT  = 12;
  localparam int RES_BITS   = 6;
  localparam int ROWS       = 4;
  // ----------------------------------------
  // Codes
  // ----------------------------------------
  localparam logic [3:0] SWS_QUARTER = 4'h0;
  localparam logic [3:0] SWS_THIRD   = 4'h1;
  localparam logic [3:0] SWS_HALF    = 4'h2;
  localparam logic [3:0] SWS_NOSCAN  = 4'h3;
  localparam logic [1:0] DET_OFF     = 2'h0;
  localparam logic [1:0] DET_SHORT   = 2'h2;
  localparam logic [6:0] PCT_FULL    = 7'h64;
  localparam logic [6:0] PCT_R1      = 7'h4b;
  localparam logic [6:0] PCT_R2      = 7'h37;
  localparam logic [6:0] PCT_R3      = 7'h1e;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS      = 100;
  localparam int SCAN_NS     = 33000;
  localparam int NOL_NS      = 1130;
  localparam int SCAN_CYC    = (SCAN_NS + CLK_NS - 1) / CLK_NS;
  localparam int NOL_CYC     = (NOL_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLOT_CYC    = SCAN_CYC + NOL_CYC;
  localparam int SLOT_W      = 9;
endpackage
`default_nettype wire

//--- lmf_scan.sv
`timescale 1ns/1ps
`default_nettype none
module lmf_scan (
  input  wire logic                     ref_clk_i,
  input  wire logic                     arst_n_i,
  input  wire logic                     run_i,
  input  wire logic [3:0]               sws_i,
  output logic      [lmf_pkg::ROWS-1:0] row_on_o,
  output logic                          blank_o
);
  import lmf_pkg::*;
  // ----------------------------------------
  // Row sequencer
  // ----------------------------------------
  logic [SLOT_W-1:0] cnt_ff;
  logic [SLOT_W-1:0] nxt_cnt;
  logic [1:0]        row_ff;
  logic [1:0]        nxt_row;
  logic [1:0]        last_row;
  logic              noscan;

  always_comb begin
    noscan = (sws_i == SWS_NOSCAN);
    case (sws_i)
      SWS_THIRD: last_row = 2'h2;
      SWS_HALF:  last_row = 2'h1;
      default:   last_row = 2'h3;
    endcase
    nxt_cnt = cnt_ff;
    nxt_row = row_ff;
    if (!run_i || noscan) begin
      nxt_cnt = '0;
      nxt_row = '0;
    end else if (cnt_ff == SLOT_W'(SLOT_CYC - 1)) begin
      nxt_cnt = '0;
      nxt_row = (row_ff >= last_row) ? 2'h0 : row_ff + 2'h1;
    end else begin
      nxt_cnt = cnt_ff + SLOT_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_ff   <= '0;
      row_ff   <= '0;
      row_on_o <= '0;
      blank_o  <= 1'b1;
    end else begin
      cnt_ff  <= nxt_cnt;
      row_ff  <= nxt_row;
      blank_o <= !run_i || (!noscan && nxt_cnt >= SLOT_W'(SCAN_CYC));
      for (int i = 0; i < ROWS; i++) begin
        row_on_o[i] <= run_i && !noscan && nxt_cnt < SLOT_W'(SCAN_CYC) && nxt_row == 2'(i);
      end
    end
  end
endmodule
`default_nettype wire

//--- lmf_regs.sv
`timescale 1ns/1ps
`default_nettype none
module lmf_regs (
  input  wire logic                                           ref_clk_i,
  input  wire logic                                           arst_n_i,
  input  wire logic                                           reg_wr_i,
  input  wire logic                                           reg_rd_i,
  input  wire logic [7:0]                                     reg_addr_i,
  input  wire logic [7:0]                                     reg_wdata_i,
  output logic      [7:0]                                     reg_rdata_o,
  input  wire logic                                           det_done_i,
  input  wire logic [lmf_pkg::RES_COUNT*lmf_pkg::RES_BITS-1:0] det_result_i,
  input  wire logic [3:0]                                     temp_over_i,
  input  wire logic [7:0]                                     dot_scale_i,
  output logic                                                shutdown_o,
  output logic      [lmf_pkg::ROWS-1:0]                       row_on_o,
  output logic                                                sink_only_o,
  output logic                                                open_start_o,
  output logic                                                short_start_o,
  output logic      [15:0]                                    dot_peak_o,
  output logic                                                phase_delay_o,
  output logic      [2:0]                                     row_pd_code_o,
  output logic      [lmf_pkg::ROWS-1:0]                       row_pd_on_o,
  output logic      [2:0]                                     col_pu_code_o,
  output logic                                                col_pu_on_o,
  output logic      [1:0]                                     temp_point_o,
  output logic                                                rolloff_active_o,
  output logic      [6:0]                                     current_pct_o,
  output logic      [7:0]                                     spread_ctrl_o
);
  import lmf_pkg::*;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic pull_on(input logic [2:0] code, input logic off_time);
    pull_on = (code != 3'h0) && (code[2] || off_time);
  endfunction

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] r);
    is_reg = reg_wr_i && (a == r);
  endfunction

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic       done_s1_ff;
  logic       done_s2_ff;
  logic       done_old_ff;
  logic [3:0] temp_s1_ff;
  logic [3:0] temp_s2_ff;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      done_s1_ff  <= 1'b0;
      done_s2_ff  <= 1'b0;
      done_old_ff <= 1'b0;
      temp_s1_ff  <= '0;
      temp_s2_ff  <= '0;
    end else begin
      done_s1_ff  <= det_done_i;
      done_s2_ff  <= done_s1_ff;
      done_old_ff <= done_s2_ff;
      temp_s1_ff  <= temp_over_i;
      temp_s2_ff  <= temp_s1_ff;
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0]          cfg_ff;
  logic [7:0]          gcs_ff;
  logic [7:0]          prs_ff;
  logic [7:0]          trs_ff;
  logic [7:0]          ssc_ff;
  logic [RES_BITS-1:0] res_ff [RES_COUNT];
  logic                armed_ff;
  logic [7:0]          nxt_cfg;
  logic [7:0]          nxt_gcs;
  logic [7:0]          nxt_prs;
  logic [7:0]          nxt_trs;
  logic [7:0]          nxt_ssc;
  logic [RES_BITS-1:0] nxt_res [RES_COUNT];
  logic                nxt_armed;
  logic                nxt_open;
  logic                nxt_short;
  logic [1:0]          wr_det;
  logic [7:0]          nxt_rdata;

  always_comb begin
    nxt_cfg   = cfg_ff;
    nxt_gcs   = gcs_ff;
    nxt_prs   = prs_ff;
    nxt_trs   = trs_ff;
    nxt_ssc   = ssc_ff;
    nxt_res   = res_ff;
    nxt_armed = armed_ff;
    nxt_open  = 1'b0;
    nxt_short = 1'b0;
    wr_det    = reg_wdata_i[CFG_DET_HI:CFG_DET_LO];
    if (is_reg(reg_addr_i, ADDR_CFG)) begin
      nxt_cfg = reg_wdata_i & MASK_CFG;
      if (wr_det == DET_OFF) begin
        nxt_armed = 1'b1;
      end else if (armed_ff) begin
        nxt_armed = 1'b0;
        nxt_open  = wr_det[0];
        nxt_short = (wr_det == DET_SHORT);
      end
    end
    if (is_reg(reg_addr_i, ADDR_GCS)) begin
      nxt_gcs = reg_wdata_i;
    end
    if (is_reg(reg_addr_i, ADDR_PRS)) begin
      nxt_prs = reg_wdata_i & MASK_PRS;
    end
    if (is_reg(reg_addr_i, ADDR_TRS)) begin
      nxt_trs = reg_wdata_i & MASK_TRS;
    end
    if (is_reg(reg_addr_i, ADDR_SSC)) begin
      nxt_ssc = reg_wdata_i & MASK_SSC;
    end
    if (done_s2_ff && !done_old_ff) begin
      for (int i = 0; i < RES_COUNT; i++) begin
        nxt_res[i] = det_result_i[i*RES_BITS +: RES_BITS];
      end
    end
    nxt_rdata = 8'h00;
    if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_CFG: nxt_rdata = cfg_ff;
        ADDR_GCS: nxt_rdata = gcs_ff;
        ADDR_PRS: nxt_rdata = prs_ff;
        ADDR_TRS: nxt_rdata = trs_ff;
        ADDR_SSC: nxt_rdata = ssc_ff;
        default: begin
          if (reg_addr_i >= ADDR_RES_LO && reg_addr_i <= ADDR_RES_HI) begin
            nxt_rdata = {2'h0, res_ff[4'(reg_addr_i - ADDR_RES_LO)]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_ff        <= RST_CFG;
      gcs_ff        <= RST_GCS;
      prs_ff        <= RST_PRS;
      trs_ff        <= RST_TRS;
      ssc_ff        <= RST_SSC;
      armed_ff      <= 1'b1;
      open_start_o  <= 1'b0;
      short_start_o <= 1'b0;
      reg_rdata_o   <= 8'h00;
      for (int i = 0; i < RES_COUNT; i++) begin
        res_ff[i] <= '0;
      end
    end else begin
      cfg_ff        <= nxt_cfg;
      gcs_ff        <= nxt_gcs;
      prs_ff        <= nxt_prs;
      trs_ff        <= nxt_trs;
      ssc_ff        <= nxt_ssc;
      armed_ff      <= nxt_armed;
      open_start_o  <= nxt_open;
      short_start_o <= nxt_short;
      reg_rdata_o   <= nxt_rdata;
      res_ff        <= nxt_res;
    end
  end

  // ----------------------------------------
  // Row scanning
  // ----------------------------------------
  logic run;
  logic blank;

  assign run = cfg_ff[CFG_SSD];

  lmf_scan u_scan (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .run_i     (run),
    .sws_i     (cfg_ff[CFG_SWS_HI:CFG_SWS_LO]),
    .row_on_o  (row_on_o),
    .blank_o   (blank)
  );

  // ----------------------------------------
  // Analog controls
  // ----------------------------------------
  logic       hot;
  logic [6:0] nxt_pct;

  always_comb begin
    hot = temp_s2_ff[trs_ff[TRS_TP_HI:TRS_TP_LO]];
    case (trs_ff[TRS_ROF_HI:TRS_ROF_LO])
      2'h1:    nxt_pct = PCT_R1;
      2'h2:    nxt_pct = PCT_R2;
      2'h3:    nxt_pct = PCT_R3;
      default: nxt_pct = PCT_FULL;
    endcase
    if (!hot) begin
      nxt_pct = PCT_FULL;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shutdown_o       <= 1'b1;
      sink_only_o      <= 1'b0;
      dot_peak_o       <= '0;
      phase_delay_o    <= 1'b0;
      row_pd_code_o    <= '0;
      row_pd_on_o      <= '0;
      col_pu_code_o    <= '0;
      col_pu_on_o      <= 1'b0;
      temp_point_o     <= '0;
      rolloff_active_o <= 1'b0;
      current_pct_o    <= PCT_FULL;
      spread_ctrl_o    <= 8'h00;
    end else begin
      shutdown_o       <= !run;
      sink_only_o      <= run && cfg_ff[CFG_SWS_HI:CFG_SWS_LO] == SWS_NOSCAN;
      dot_peak_o       <= gcs_ff * dot_scale_i;
      phase_delay_o    <= prs_ff[PRS_PHC];
      row_pd_code_o    <= prs_ff[PRS_RPD_HI:PRS_RPD_LO];
      for (int i = 0; i < ROWS; i++) begin
        row_pd_on_o[i] <= pull_on(prs_ff[PRS_RPD_HI:PRS_RPD_LO], !row_on_o[i]);
      end
      col_pu_code_o    <= prs_ff[PRS_CPU_HI:PRS_CPU_LO];
      col_pu_on_o      <= pull_on(prs_ff[PRS_CPU_HI:PRS_CPU_LO], blank);
      temp_point_o     <= trs_ff[TRS_TP_HI:TRS_TP_LO];
      rolloff_active_o <= hot;
      current_pct_o    <= nxt_pct;
      spread_ctrl_o    <= ssc_ff;
    end
  end
endmodule
`default_nettype wire

//--- lmf_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Register bank checks
// ----------------------------------------
module lmf_regs_properties (
  input  wire logic                     ref_clk_i,
  input  wire logic                     arst_n_i,
  input  wire logic                     reg_wr_i,
  input  wire logic                     reg_rd_i,
  input  wire logic [7:0]               reg_addr_i,
  input  wire logic [7:0]               reg_wdata_i,
  input  wire logic [7:0]               reg_rdata_o,
  input  wire logic [7:0]               dot_scale_i,
  input  wire logic                     shutdown_o,
  input  wire logic [lmf_pkg::ROWS-1:0] row_on_o,
  input  wire logic                     open_start_o,
  input  wire logic                     short_start_o,
  input  wire logic [15:0]              dot_peak_o,
  input  wire logic                     phase_delay_o,
  input  wire logic [2:0]               row_pd_code_o,
  input  wire logic [1:0]               temp_point_o,
  input  wire logic                     rolloff_active_o,
  input  wire logic [6:0]               current_pct_o
);
  import lmf_pkg::*;
  logic       w50;
  logic       trig;
  logic       armed_ff;
  logic [7:0] gcs_ff;
  assign w50 = reg_wr_i && reg_addr_i == ADDR_CFG;
  assign trig = w50 && armed_ff && reg_wdata_i[2:1] != DET_OFF;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      armed_ff <= 1'h1;
      gcs_ff <= 8'h00;
    end else begin
      if (w50) armed_ff <= reg_wdata_i[2:1] == DET_OFF;
      if (reg_wr_i && reg_addr_i == ADDR_GCS) gcs_ff <= reg_wdata_i;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence open_req_s;
    trig && reg_wdata_i[1];
  endsequence
  sequence short_req_s;
    trig && reg_wdata_i[2:1] == DET_SHORT;
  endsequence
  open_pulse_a: assert property (open_req_s |=> open_start_o && !short_start_o)
    else $error("open start missing");
  short_pulse_a: assert property (short_req_s |=> short_start_o && !open_start_o)
    else $error("short start missing");
  start_once_a: assert property (!trig |=> !open_start_o && !short_start_o)
    else $error("unexpected start pulse");
  shutdown_bit_a: assert property (w50 |-> ##2 shutdown_o == !$past(reg_wdata_i[0], 2))
    else $error("shutdown mismatch");
  phase_sel_a: assert property (reg_wr_i && reg_addr_i == ADDR_PRS |-> ##2
    phase_delay_o == $past(reg_wdata_i[7], 2) && row_pd_code_o == $past(reg_wdata_i[6:4], 2))
    else $error("resistor select mismatch");
  dot_peak_a: assert property (dot_peak_o == $past(gcs_ff) * $past(dot_scale_i))
    else $error("peak product mismatch");
  row_hot_a: assert property ($onehot0(row_on_o))
    else $error("rows overlap");
  temp_point_a: assert property (reg_wr_i && reg_addr_i == ADDR_TRS |-> ##2
    temp_point_o == $past(reg_wdata_i[3:2], 2))
    else $error("temperature point mismatch");
  full_current_a: assert property (!rolloff_active_o |-> current_pct_o == PCT_FULL)
    else $error("current reduced without rolloff");
  result_top_a: assert property (reg_rd_i && reg_addr_i inside {[ADDR_RES_LO:ADDR_RES_HI]} |=>
    reg_rdata_o[7:6] == 2'h0)
    else $error("result top bits set");
endmodule
`default_nettype wire

//--- lmf_det_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Detection engine stand-in
// ----------------------------------------
module lmf_det_model #(
  parameter int DLY = 40
)
(
  input  wire logic                                           ref_clk_i,
  input  wire logic                                           arst_n_i,
  input  wire logic                                           open_start_i,
  input  wire logic                                           short_start_i,
  output logic                                                det_done_o,
  output logic      [lmf_pkg::RES_COUNT*lmf_pkg::RES_BITS-1:0] det_result_o
);
  import lmf_pkg::*;
  int   cnt_ff;
  logic short_ff;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_ff <= 0;
      short_ff <= 1'h0;
      det_done_o <= 1'h0;
    end else if (open_start_i || short_start_i) begin
      cnt_ff <= DLY;
      short_ff <= short_start_i;
      det_done_o <= 1'h0;
    end else if (cnt_ff != 0) begin
      cnt_ff <= cnt_ff - 1;
      det_done_o <= cnt_ff == 1;
    end
  end
  // Results are inverted while a pass runs, so early capture shows up.
  always_comb begin
    for (int i = 0; i < RES_COUNT; i++) begin
      det_result_o[i*RES_BITS +: RES_BITS] = short_ff ? 6'(63 - i) : 6'(i + 1);
      if (cnt_ff != 0) det_result_o[i*RES_BITS +: RES_BITS] = ~det_result_o[i*RES_BITS +: RES_BITS];
    end
  end
endmodule
`default_nettype wire

//--- lmf_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Register bank bench
// ----------------------------------------
module lmf_regs_tb_top;
  import lmf_pkg::*;
  logic        ref_clk_i, arst_n_i, reg_wr_i, reg_rd_i, det_done_i, shutdown_o, sink_only_o;
  logic        open_start_o, short_start_o, phase_delay_o, col_pu_on_o, rolloff_active_o;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, dot_scale_i, spread_ctrl_o, seen;
  logic [3:0]  temp_over_i, row_on_o, row_pd_on_o;
  logic [2:0]  row_pd_code_o, col_pu_code_o;
  logic [1:0]  temp_point_o;
  logic [6:0]  current_pct_o;
  logic [15:0] dot_peak_o;
  logic [71:0] det_result_i;
  int          fails, total_checks, cyc, n_open, n_short;
  logic [7:0]  ra[7] = '{8'h50, 8'h51, 8'h52, 8'h53, 8'h5e, 8'h5f, 8'h60};
  logic [7:0]  rv[7] = '{8'h00, 8'h00, 8'h33, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  wa[6] = '{8'h51, 8'h52, 8'h5f, 8'h60, 8'h53, 8'h70};
  logic [7:0]  we[6] = '{8'hff, 8'hf7, 8'h0f, 8'h1f, 8'h00, 8'h00};
  logic [3:0]  sc[6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hf};
  logic [3:0]  er[6] = '{4'hf, 4'h7, 4'h3, 4'h0, 4'hf, 4'hf};
  logic [6:0]  pe[4] = '{7'h64, 7'h4b, 7'h37, 7'h1e};
  lmf_regs dut_u (.ref_clk_i, .arst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
    .det_done_i, .det_result_i, .temp_over_i, .dot_scale_i, .shutdown_o, .row_on_o, .sink_only_o,
    .open_start_o, .short_start_o, .dot_peak_o, .phase_delay_o, .row_pd_code_o, .row_pd_on_o,
    .col_pu_code_o, .col_pu_on_o, .temp_point_o, .rolloff_active_o, .current_pct_o, .spread_ctrl_o);
  lmf_det_model det_u (.ref_clk_i, .arst_n_i, .open_start_i(open_start_o), .short_start_i(short_start_o),
    .det_done_o(det_done_i), .det_result_o(det_result_i));
  initial begin
    ref_clk_i = 1'h0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  task automatic give_verdict;
    if (fails == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc++;
    if (open_start_o === 1'h1) n_open++;
    if (short_start_o === 1'h1) n_short++;
    if (cyc == 30000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'h1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'h0;
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'h1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'h0;
    @(negedge ref_clk_i);
    chk(n, e, reg_rdata_o);
  endtask
  task automatic pass_chk(input logic sh);
    repeat (3) @(posedge ref_clk_i);
    for (int k = 0; k < 200 && det_done_i !== 1'h1; k++) @(posedge ref_clk_i);
    repeat (6) @(posedge ref_clk_i);
    for (int i = 0; i < 12; i++) rd_chk("result", ADDR_RES_LO + 8'(i), sh ? 8'(63 - i) : 8'(i + 1));
  endtask
  initial begin
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, temp_over_i, dot_scale_i, arst_n_i} = '0;
    repeat (16) @(posedge ref_clk_i);
    arst_n_i <= 1'h1;
    for (int i = 0; i < 7; i++) rd_chk("reset", ra[i], rv[i]);
    chk("shutdown", 16'h1, shutdown_o);
    chk("pct", 16'h64, current_pct_o);
    chk("pd_on", 16'hf, row_pd_on_o);
    chk("pu_on", 16'h1, col_pu_on_o);
    for (int i = 0; i < 6; i++) begin
      wr_reg(wa[i], 8'hff);
      rd_chk("mask", wa[i], we[i]);
    end
    chk("phase", 16'h1, phase_delay_o);
    chk("pd", 16'h7, row_pd_code_o);
    chk("pu", 16'h7, col_pu_code_o);
    chk("pd_on", 16'hf, row_pd_on_o);
    chk("pu_on", 16'h1, col_pu_on_o);
    chk("tp", 16'h3, temp_point_o);
    chk("spread", 16'h1f, spread_ctrl_o);
    wr_reg(ADDR_PRS, 8'h00);
    wr_reg(ADDR_GCS, 8'h40);
    dot_scale_i <= 8'hff;
    repeat (3) @(negedge ref_clk_i);
    chk("pd_on", 16'h0, row_pd_on_o);
    chk("pu_on", 16'h0, col_pu_on_o);
    chk("phase", 16'h0, phase_delay_o);
    chk("peak", 16'h3fc0, dot_peak_o);
    wr_reg(ADDR_CFG, 8'h03);
    pass_chk(1'h0);
    chk("shutdown", 16'h0, shutdown_o);
    wr_reg(ADDR_CFG, 8'h03);
    wr_reg(ADDR_CFG, 8'h01);
    wr_reg(ADDR_CFG, 8'h05);
    pass_chk(1'h1);
    wr_reg(ADDR_CFG, 8'h05);
    wr_reg(ADDR_CFG, 8'h01);
    wr_reg(ADDR_CFG, 8'h07);
    pass_chk(1'h0);
    chk("opens", 16'h2, 16'(n_open));
    chk("shorts", 16'h1, 16'(n_short));
    for (int i = 0; i < 6; i++) begin
      wr_reg(ADDR_CFG, {sc[i], 4'h1});
      repeat (400) @(posedge ref_clk_i);
      seen = '0;
      repeat (1400) @(negedge ref_clk_i) seen |= 8'(row_on_o);
      chk("rows", 16'(er[i]), 16'(seen));
      chk("sink_only", 16'(sc[i] == SWS_NOSCAN), sink_only_o);
    end
    for (int r = 0; r < 4; r++) begin
      wr_reg(ADDR_TRS, {4'h0, 2'(r), 2'(r)});
      temp_over_i <= 4'(4'he << r);
      repeat (6) @(negedge ref_clk_i);
      chk("tp", 16'(r), temp_point_o);
      chk("roll", 16'h0, rolloff_active_o);
      chk("pct", 16'h64, current_pct_o);
      @(posedge ref_clk_i);
      temp_over_i <= 4'(4'hf << r);
      repeat (6) @(negedge ref_clk_i);
      chk("roll", 16'h1, rolloff_active_o);
      chk("pct", 16'(pe[r]), current_pct_o);
      @(posedge ref_clk_i);
      temp_over_i <= 4'h0;
    end
    give_verdict();
  end
endmodule
bind lmf_regs lmf_regs_properties prop_u (.ref_clk_i, .arst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
  .reg_wdata_i, .reg_rdata_o, .dot_scale_i, .shutdown_o, .row_on_o, .open_start_o, .short_start_o,
  .dot_peak_o, .phase_delay_o, .row_pd_code_o, .temp_point_o, .rolloff_active_o, .current_pct_o);
`default_nettype wire
